// ==== verilog/pss_config_regs.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Protectable tempco byte, resets to 2Ch.
// - Bit7 clear selects internal temperature sensor.
// - Resistance is gain times one plus correction.
// - Correction applied negatively against positive coefficient.
// - Upper byte high-low, lower low-high, signed ns.
// - Positive means gap, negative means overlap.
// - Frozen runs written value between min and max.
// - Switching to frozen keeps last applied time.
// - Dead time resets 1018h, span -15 to 60.
// - Mode bits 15 and 7: adaptive or frozen.
// - Minimum fields in 2ns steps bound adaptive.
// - Mode config resets to 8686h.
// - Enable needs enable state and prequel power-good.
// - Sequel power-down starts delayed output turn-off.
// - Sequencing enables and rail IDs per byte.
// - Written sequencing overrides strap configuration.
// - Sequencing resets to 0000h; the strap applies until written.
// - Tracking bit7 enables, resets to 00h.
// - Bit2 selects 100 or 50 percent ratio.
// - Bit1 selects target or reference upper limit.
// - Bit0 allows downward following before power-good.
module pss_config_regs
	import pss_pkg::*;
(
	// Clock and reset.
	input  wire logic               clk,
	input  wire logic               reset_n,
	// Command port from the PMBus front end.
	input  wire logic [7:0]         cmdCode,
	input  wire logic               cmdWrite,
	input  wire logic               cmdRead,
	input  wire logic [15:0]        cmdWrData,
	input  wire logic               writeProtect,
	output logic      [15:0]        cmdRdData,
	output logic                    cmdRdValid,
	output logic                    cmdError,
	// Current sense temperature correction.
	input  wire logic [15:0]        currentSenseGain,
	input  wire logic signed [7:0]  internalTemp,
	input  wire logic signed [7:0]  externalTemp,
	output logic signed [17:0]      senseResistance,
	output logic signed [17:0]      correctedGain,
	// Dead time.
	input  wire logic signed [7:0]  adaptHlTime,
	input  wire logic signed [7:0]  adaptLhTime,
	input  wire logic signed [7:0]  hlUpperLimit,
	input  wire logic signed [7:0]  lhUpperLimit,
	output logic signed [7:0]       hlDeadTime,
	output logic signed [7:0]       lhDeadTime,
	output logic                    hlOverlap,
	output logic                    lhOverlap,
	// Sequencing over the inter-rail bus.
	input  wire logic               enablePin,
	input  wire logic [15:0]        strapSequence,
	input  wire logic               busEventValid,
	input  wire logic [4:0]         busEventId,
	input  wire logic               busPowerGood,
	input  wire logic               busPowerDown,
	input  wire logic [15:0]        turnOffDelay,
	output logic                    outputEnable,
	// Voltage tracking.
	input  wire logic [11:0]        followReferenceInput,
	input  wire logic [11:0]        targetVoltage,
	input  wire logic               powerGoodOutput,
	output logic [11:0]             trackSetpoint,
	output logic                    trackActive
);

	// Command registers.
	logic [7:0]  tempco;    // Temperature correction byte.
	logic [15:0] dtime;     // Written or frozen dead times.
	logic [15:0] dtCfg;     // Mode bits and minimums.
	logic [15:0] seqReg;    // Sequencing links.
	logic        seqWritten;// Host has written sequencing.
	logic [7:0]  track;     // Tracking configuration.

	// Pin synchronisers.
	logic [1:0]  enSync;
	logic [15:0] strapMeta;
	logic [15:0] strapSync;

	// Dead times in use, index 1 high-low and index 0 low-high.
	logic signed [7:0] dtApplied [2];
	logic              dtOver    [2];

	// Decoded write strobes.
	logic wrTempco;
	logic wrDt;
	logic wrDtCfg;
	logic wrSeq;
	logic wrTrack;

	assign wrTempco = cmdWrite && cmdCode == CMD_TEMPCO && !writeProtect;
	assign wrDt     = cmdWrite && cmdCode == CMD_DT;
	assign wrDtCfg  = cmdWrite && cmdCode == CMD_DTCFG;
	assign wrSeq    = cmdWrite && cmdCode == CMD_SEQ;
	assign wrTrack  = cmdWrite && cmdCode == CMD_TRACK;

	// Saturate a written dead time into the accepted span.
	function automatic logic [7:0] spanDt(input logic signed [7:0] v);
		logic signed [7:0] r;
		r = (v < DT_LOW_NS) ? DT_LOW_NS : v;
		if (r > DT_HIGH_NS) begin
			r = DT_HIGH_NS;
		end
		return r;
	endfunction

	// Clamp to a floor and a ceiling; the ceiling wins if they cross.
	function automatic logic signed [9:0] dtClamp(
		input logic signed [9:0] v,
		input logic signed [9:0] lo,
		input logic signed [9:0] hi
	);
		logic signed [9:0] r;
		r = (v < lo) ? lo : v;
		if (r > hi) begin
			r = hi;
		end
		return r;
	endfunction

	// Both pins cross from outside, so each passes two flops.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			enSync    <= 2'h0;
			strapMeta <= 16'h0000;
			strapSync <= 16'h0000;
		end else begin
			enSync    <= {enSync[0], enablePin};
			strapMeta <= strapSequence;
			strapSync <= strapMeta;
		end
	end

	// Temperature correction byte.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tempco <= TEMPCO_RST;
		end else if (wrTempco) begin
			tempco <= cmdWrData[7:0];
		end
	end

	// Dead time word: host writes, or capture on a switch to frozen.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dtime <= DT_RST;
		end else if (wrDt) begin
			dtime <= {spanDt(cmdWrData[15:8]), spanDt(cmdWrData[7:0])};
		end else if (wrDtCfg) begin
			for (int i = 0; i < 2; i++) begin
				// Freezing keeps the time last in use, not the old value.
				if (!dtCfg[i*8+DT_MODE_BIT] && cmdWrData[i*8+DT_MODE_BIT]) begin
					dtime[i*8 +: 8] <= dtApplied[i];
				end
			end
		end
	end

	// Dead time mode configuration.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dtCfg <= DTCFG_RST;
		end else if (wrDtCfg) begin
			dtCfg <= cmdWrData;
		end
	end

	// Sequencing word; reserved bits are dropped on write.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			seqReg     <= SEQ_RST;
			seqWritten <= 1'b0;
		end else if (wrSeq) begin
			seqReg     <= cmdWrData & SEQ_MASK;
			seqWritten <= 1'b1;
		end
	end

	// Tracking byte; reserved bits are dropped on write.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			track <= TRACK_RST;
		end else if (wrTrack) begin
			track <= cmdWrData[7:0] & TRACK_MASK;
		end
	end

	// Read-back, with an error pulse for unknown codes.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmdRdData  <= 16'h0000;
			cmdRdValid <= 1'b0;
			cmdError   <= 1'b0;
		end else begin
			cmdRdValid <= cmdRead;
			cmdError   <= 1'b0;
			if (cmdRead) begin
				case (cmdCode)
					CMD_TEMPCO: cmdRdData <= {8'h00, tempco};
					CMD_DT:     cmdRdData <= dtime;
					CMD_DTCFG:  cmdRdData <= dtCfg;
					CMD_SEQ:    cmdRdData <= seqReg;
					CMD_TRACK:  cmdRdData <= {8'h00, track};
					default: begin
						cmdRdData <= 16'h0000;
						cmdError  <= 1'b1;
					end
				endcase
			end else if (cmdWrite) begin
				case (cmdCode)
					CMD_TEMPCO, CMD_DT, CMD_DTCFG, CMD_SEQ, CMD_TRACK: begin
						cmdError <= 1'b0;
					end
					default: cmdError <= 1'b1;
				endcase
			end
		end
	end

	// Temperature correction arithmetic.
	logic signed [7:0]  tempSel;
	logic signed [9:0]  tempDiff;
	logic signed [34:0] corrProduct;
	logic signed [34:0] corrDelta;
	logic signed [17:0] gainExt;

	assign tempSel  = tempco[TEMP_SRC_BIT] ? externalTemp : internalTemp;
	assign tempDiff = 10'(tempSel) - REF_TEMP;
	assign corrProduct = $signed({1'b0, currentSenseGain})
		* $signed({1'b0, tempco[CORR_FACTOR_W-1:0]}) * tempDiff;
	assign corrDelta = corrProduct / PPM_DIV;
	assign gainExt = $signed({2'h0, currentSenseGain});

	// Resistance follows the coefficient; gain is corrected against it.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			senseResistance <= 18'sh00000;
			correctedGain   <= 18'sh00000;
		end else begin
			senseResistance <= gainExt + corrDelta[17:0];
			correctedGain   <= gainExt - corrDelta[17:0];
		end
	end

	// One dead time channel per transition direction.
	logic signed [7:0] adaptArr [2];
	logic signed [7:0] upperArr [2];
	assign adaptArr[1] = adaptHlTime;
	assign adaptArr[0] = adaptLhTime;
	assign upperArr[1] = hlUpperLimit;
	assign upperArr[0] = lhUpperLimit;

	for (genvar g = 0; g < 2; g++) begin : gDt
		logic signed [9:0] lo;
		logic signed [9:0] hi;
		logic signed [9:0] src;
		logic signed [9:0] val;
		// Minimum is in 2 ns steps.
		assign lo  = $signed({2'h0, dtCfg[g*8 +: DT_MIN_W], 1'b0});
		assign hi  = 10'(upperArr[g]);
		assign src = dtCfg[g*8+DT_MODE_BIT] ? 10'($signed(dtime[g*8 +: 8]))
			: 10'(adaptArr[g]);
		assign val = dtClamp(src, lo, hi);

		// Registered time in use and its gap or overlap sense.
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				dtApplied[g] <= DT_RST[g*8 +: 8];
				dtOver[g]    <= 1'b0;
			end else begin
				dtApplied[g] <= val[7:0];
				dtOver[g]    <= val[9];
			end
		end
	end

	assign hlDeadTime = dtApplied[1];
	assign lhDeadTime = dtApplied[0];
	assign hlOverlap  = dtOver[1];
	assign lhOverlap  = dtOver[0];

	// Effective sequencing: the strap applies until a host write.
	logic [15:0] seqEff;
	logic        preEn;
	logic        postEn;
	logic        preEvt;
	logic        postEvt;
	assign seqEff  = seqWritten ? seqReg : (strapSync & SEQ_MASK);
	assign preEn   = seqEff[8+SEQ_EN_BIT];
	assign postEn  = seqEff[SEQ_EN_BIT];
	assign preEvt  = busEventValid && busEventId == seqEff[8 +: SEQ_ID_W];
	assign postEvt = busEventValid && busEventId == seqEff[0 +: SEQ_ID_W];

	// Latched rail events; a good and a down event cancel each other.
	logic preGood;
	logic postDown;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			preGood  <= 1'b0;
			postDown <= 1'b0;
		end else begin
			if (preEvt && busPowerGood) begin
				preGood <= 1'b1;
			end else if (preEvt && busPowerDown) begin
				preGood <= 1'b0;
			end
			if (postEvt && busPowerDown) begin
				postDown <= 1'b1;
			end else if (postEvt && busPowerGood) begin
				postDown <= 1'b0;
			end
		end
	end

	// Output enable sequencer with turn-off delay.
	pss_rail_t   railState;
	logic [15:0] offCount;
	logic        startOk;
	logic        stopReq;
	assign startOk = enSync[1] && (!preEn || preGood) && !(postEn && postDown);
	assign stopReq = !enSync[1] || (postEn && postDown);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			railState    <= PSS_OFF;
			offCount     <= 16'h0000;
			outputEnable <= 1'b0;
		end else begin
			case (railState)
				PSS_OFF: begin
					if (startOk) begin
						railState    <= PSS_ON;
						outputEnable <= 1'b1;
					end
				end
				PSS_ON: begin
					if (stopReq) begin
						railState <= PSS_STOP;
						offCount  <= turnOffDelay;
					end
				end
				PSS_STOP: begin
					if (offCount == 16'h0000) begin
						railState    <= PSS_OFF;
						outputEnable <= 1'b0;
					end else begin
						offCount <= offCount - 16'h0001;
					end
				end
				default: begin
					railState    <= PSS_OFF;
					outputEnable <= 1'b0;
				end
			endcase
		end
	end

	// Tracking setpoint.
	logic [11:0] trkScaled;
	logic [11:0] trkLimit;
	logic [11:0] trkCand;
	assign trkScaled = track[TRK_HALF_BIT] ? {1'b0, followReferenceInput[11:1]}
		: followReferenceInput;
	assign trkLimit = track[TRK_LIM_BIT] ? followReferenceInput
		: targetVoltage;
	assign trkCand = (trkScaled < trkLimit) ? trkScaled : trkLimit;

	// Falling reference is ignored before power-good unless allowed.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trackSetpoint <= 12'h000;
			trackActive   <= 1'b0;
		end else if (!track[TRK_EN_BIT]) begin
			trackSetpoint <= targetVoltage;
			trackActive   <= 1'b0;
		end else begin
			trackActive <= 1'b1;
			if (!(trkCand < trackSetpoint && !track[TRK_DOWN_BIT]
				&& !powerGoodOutput)) begin
				trackSetpoint <= trkCand;
			end
		end
	end

	// Checks.
	sequence sSequelDown;
		railState == PSS_ON && postEn && postDown;
	endsequence
	sequence sOffDelay;
		railState == PSS_STOP && outputEnable;
	endsequence

	a_tempco_protect: assert property (@(posedge clk) disable iff (!reset_n)
		cmdWrite && cmdCode == CMD_TEMPCO && writeProtect |=> $stable(tempco))
		else $error("protected tempco byte changed");
	a_temp_source: assert property (@(posedge clk) disable iff (!reset_n)
		!tempco[TEMP_SRC_BIT] |-> tempSel == internalTemp)
		else $error("internal sensor not selected");
	a_overlap_sign: assert property (@(posedge clk) disable iff (!reset_n)
		hlOverlap == (hlDeadTime < 0) && lhOverlap == (lhDeadTime < 0))
		else $error("overlap flag disagrees with dead time");
	a_frozen_floor: assert property (@(posedge clk) disable iff (!reset_n)
		gDt[1].lo <= gDt[1].hi |=> 10'(hlDeadTime) >= $past(gDt[1].lo))
		else $error("dead time below minimum");
	a_freeze_keep: assert property (@(posedge clk) disable iff (!reset_n)
		wrDtCfg && !dtCfg[15] && cmdWrData[15]
		|=> dtime[15:8] == $past(hlDeadTime))
		else $error("freeze did not keep last dead time");
	a_dt_span: assert property (@(posedge clk) disable iff (!reset_n)
		wrDt |=> $signed(dtime[7:0]) >= DT_LOW_NS
		&& $signed(dtime[15:8]) <= DT_HIGH_NS)
		else $error("written dead time outside span");
	a_rsvd_zero: assert property (@(posedge clk) disable iff (!reset_n)
		(seqReg & ~SEQ_MASK) == 16'h0000 && (track & ~TRACK_MASK) == 8'h00)
		else $error("reserved bits not zero");
	a_prequel_gate: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(outputEnable) |-> $past(!preEn || preGood) && $past(enSync[1]))
		else $error("output enabled without prequel power-good");
	a_sequel_stop: assert property (@(posedge clk) disable iff (!reset_n)
		sSequelDown |=> sOffDelay)
		else $error("sequel power-down did not start turn-off");
	a_track_limit: assert property (@(posedge clk) disable iff (!reset_n)
		track[TRK_EN_BIT] && $stable(track) && powerGoodOutput
		|=> trackSetpoint <= $past(trkLimit))
		else $error("tracking setpoint above limit");
endmodule

// ==== shared/pss_pkg.sv ====
package pss_pkg;
	// Command codes of the configuration commands.
	localparam logic [7:0] CMD_TEMPCO = 8'hdc;
	localparam logic [7:0] CMD_DT     = 8'hdd;
	localparam logic [7:0] CMD_DTCFG  = 8'hde;
	localparam logic [7:0] CMD_SEQ    = 8'he0;
	localparam logic [7:0] CMD_TRACK  = 8'he1;

	// Values after reset.
	localparam logic [7:0]  TEMPCO_RST = 8'h2c;
	localparam logic [15:0] DT_RST     = 16'h1018;
	localparam logic [15:0] DTCFG_RST  = 16'h8686;
	localparam logic [15:0] SEQ_RST    = 16'h0000;
	localparam logic [7:0]  TRACK_RST  = 8'h00;

	// Masks of the implemented bits; reserved bits are zero.
	localparam logic [15:0] SEQ_MASK   = 16'h9f9f;
	localparam logic [7:0]  TRACK_MASK = 8'h87;

	// Field positions.
	localparam int TEMP_SRC_BIT  = 7;
	localparam int CORR_FACTOR_W = 7;
	localparam int DT_MODE_BIT  = 7;
	localparam int DT_MIN_W     = 7;
	localparam int SEQ_EN_BIT   = 7;
	localparam int SEQ_ID_W     = 5;
	localparam int TRK_EN_BIT   = 7;
	localparam int TRK_HALF_BIT = 2;
	localparam int TRK_LIM_BIT  = 1;
	localparam int TRK_DOWN_BIT = 0;

	// Accepted span of a written dead time, in ns.
	localparam logic signed [7:0] DT_LOW_NS  = 8'shf1;
	localparam logic signed [7:0] DT_HIGH_NS = 8'sh3c;

	// Reference temperature and the 100 ppm scale of the factor.
	localparam logic signed [9:0]  REF_TEMP = 10'sh019;
	localparam logic signed [34:0] PPM_DIV  = 35'sh2710;

	// Output sequencing states.
	typedef enum logic [1:0] {
		PSS_OFF  = 2'h0,
		PSS_ON   = 2'h1,
		PSS_STOP = 2'h2
	} pss_rail_t;
endpackage

// ==== tb/pss_rail_peer.sv ====
`timescale 1ns/1ps
// Behavioural peer rail on the inter-rail bus; it sends one event per request.
module pss_rail_peer (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Requests from the bench.
	input  wire logic       sendReq,
	input  wire logic [4:0] sendId,
	input  wire logic       sendGood,
	// Inter-rail bus event lines.
	output logic            busEventValid,
	output logic [4:0]      busEventId,
	output logic            busPowerGood,
	output logic            busPowerDown
);
	// Between events the qualifiers toggle, so the design must not use them.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busEventValid <= 1'b0;
			busEventId    <= 5'h00;
			busPowerGood  <= 1'b0;
			busPowerDown  <= 1'b0;
		end else if (sendReq) begin
			// A power-good or a power-down event from one rail.
			busEventValid <= 1'b1;
			busEventId    <= sendId;
			busPowerGood  <= sendGood;
			busPowerDown  <= !sendGood;
		end else begin
			busEventValid <= 1'b0;
			busEventId    <= ~busEventId;
			busPowerGood  <= ~busPowerGood;
			busPowerDown  <= ~busPowerDown;
		end
	end
endmodule

// ==== tb/pss_config_regs_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench of the configuration command block.
module pss_config_regs_tb;
	import pss_pkg::*;
	logic               clk, reset_n, cmdWrite, cmdRead, writeProtect;
	logic [7:0]         cmdCode;
	logic [15:0]        cmdWrData, cmdRdData, currentSenseGain, strapSequence;
	logic               cmdRdValid, cmdError, hlOverlap, lhOverlap;
	logic signed [7:0]  internalTemp, externalTemp, adaptHlTime, adaptLhTime;
	logic signed [7:0]  hlUpperLimit, lhUpperLimit, hlDeadTime, lhDeadTime;
	logic signed [17:0] senseResistance, correctedGain;
	logic               enablePin, busEventValid, busPowerGood, busPowerDown;
	logic [4:0]         busEventId, sendId;
	logic               sendReq, sendGood, outputEnable, powerGoodOutput;
	logic [15:0]        turnOffDelay;
	logic [11:0]        followReferenceInput, targetVoltage, trackSetpoint;
	logic               trackActive;
	int                 errors, comparisons, n, r, a, b;
	logic [16:0]        expQ[$]; // Expected {error, read data} per answer.

	pss_config_regs u_pss_config_regs (.clk(clk), .reset_n(reset_n),
		.cmdCode(cmdCode), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
		.cmdWrData(cmdWrData), .writeProtect(writeProtect),
		.cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .cmdError(cmdError),
		.currentSenseGain(currentSenseGain), .internalTemp(internalTemp),
		.externalTemp(externalTemp), .senseResistance(senseResistance),
		.correctedGain(correctedGain), .adaptHlTime(adaptHlTime),
		.adaptLhTime(adaptLhTime), .hlUpperLimit(hlUpperLimit),
		.lhUpperLimit(lhUpperLimit), .hlDeadTime(hlDeadTime),
		.lhDeadTime(lhDeadTime), .hlOverlap(hlOverlap), .lhOverlap(lhOverlap),
		.enablePin(enablePin), .strapSequence(strapSequence),
		.busEventValid(busEventValid), .busEventId(busEventId),
		.busPowerGood(busPowerGood), .busPowerDown(busPowerDown),
		.turnOffDelay(turnOffDelay), .outputEnable(outputEnable),
		.followReferenceInput(followReferenceInput),
		.targetVoltage(targetVoltage), .powerGoodOutput(powerGoodOutput),
		.trackSetpoint(trackSetpoint), .trackActive(trackActive));

	pss_rail_peer u_pss_rail_peer (.clk(clk), .reset_n(reset_n),
		.sendReq(sendReq), .sendId(sendId), .sendGood(sendGood),
		.busEventValid(busEventValid), .busEventId(busEventId),
		.busPowerGood(busPowerGood), .busPowerDown(busPowerDown));

	// Free-running 200 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Counts a comparison and reports it at once when it differs.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Waits k edges; inputs always change 1 ns after an edge.
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// One command cycle, then an idle edge so strobes never glitch.
	task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
		cmdWrite  = w;
		cmdRead   = !w;
		cmdCode   = c;
		cmdWrData = d;
		tick(1);
		cmdWrite = 1'b0;
		cmdRead  = 1'b0;
		tick(1);
	endtask

	// A read notes its expected answer before the request goes out.
	task automatic rd(input logic [7:0] c, input logic [16:0] e);
		expQ.push_back(e);
		cmd(1'b0, c, 16'h0000);
	endtask

	// One inter-rail event from the peer model.
	task automatic ev(input logic [4:0] id, input logic good);
		sendReq  = 1'b1;
		sendId   = id;
		sendGood = good;
		tick(1);
		sendReq = 1'b0;
		tick(1);
	endtask

	// Bounded wait for a level of the output enable; n counts the edges.
	task automatic waitOe(input logic v, input int lim);
		n = 0;
		while (outputEnable !== v && n < lim) begin
			tick(1);
			n++;
		end
	endtask

	// Each answer of the block takes the oldest note off the queue.
	always @(posedge clk) begin
		if (reset_n && (cmdRdValid === 1'b1 || cmdError === 1'b1)) begin
			if (expQ.size() == 0)
				check({cmdError, cmdRdData}, 17'h1ffff);
			else
				check({cmdError, cmdRdData}, expQ.pop_front());
		end
	end

	// Watchdog sized well beyond the expected run of about 150 cycles.
	initial begin
		#50000;
		errors++;
		$display("Watchdog expired");
		wrap_up();
	end

	initial begin
		{cmdWrite, cmdRead, writeProtect, sendReq, sendGood} = 5'h00;
		{cmdCode, cmdWrData, sendId} = 29'h0;
		currentSenseGain = 16'd1000;
		internalTemp = 8'sd75;
		externalTemp = 8'sd25;
		{adaptHlTime, adaptLhTime} = 16'h1414;
		hlUpperLimit = 8'sd60;
		lhUpperLimit = 8'sd60;
		enablePin = 1'b1;
		strapSequence = 16'h8101; // Strap asks for a prequel on rail 1.
		turnOffDelay = 16'h0004;
		followReferenceInput = 12'h400;
		targetVoltage = 12'h800;
		powerGoodOutput = 1'b1;
		reset_n = 1'b0;
		void'($urandom(74997));
		repeat (20) @(posedge clk);
		#1;
		reset_n = 1'b1;
		// Reset values of every command and of the derived outputs.
		rd(CMD_TEMPCO, 17'h0002c);
		rd(CMD_DT, 17'h01018);
		rd(CMD_DTCFG, 17'h08686);
		rd(CMD_SEQ, 17'h00000);
		rd(CMD_TRACK, 17'h00000);
		rd(8'hdf, 17'h10000);
		tick(2);
		check(hlDeadTime, 8'sd16);
		check(lhDeadTime, 8'sd24);
		check(senseResistance, 18'sd1220);
		check(correctedGain, 18'sd780);
		check(trackSetpoint, 12'h800);
		check(outputEnable, 1'b0);
		// Temperature factor kept within the supported span.
		r = $urandom % 64;
		cmd(1'b1, CMD_TEMPCO, 16'(r));
		writeProtect = 1'b1;
		cmd(1'b1, CMD_TEMPCO, 16'h0080);
		rd(CMD_TEMPCO, 17'(r));
		tick(2);
		check(senseResistance, 18'(1000 + 5 * r));
		check(correctedGain, 18'(1000 - 5 * r));
		writeProtect = 1'b0;
		cmd(1'b1, CMD_TEMPCO, 16'(r + 128));
		tick(2);
		check(senseResistance, 18'sd1000);
		// Frozen dead times, overlap sign, saturation and upper limit.
		cmd(1'b1, CMD_DTCFG, 16'h8080);
		cmd(1'b1, CMD_DT, 16'hf528);
		rd(CMD_DT, 17'h0f528);
		tick(2);
		check(hlDeadTime, 8'sd0);
		check(lhDeadTime, 8'sd40);
		// A limit below zero is the only way to reach an overlap.
		hlUpperLimit = -8'sd11;
		tick(2);
		check(hlDeadTime, -8'sd11);
		check({hlOverlap, lhOverlap}, 2'b10);
		cmd(1'b1, CMD_DT, 16'h7f80);
		rd(CMD_DT, 17'h03cf1);
		hlUpperLimit = 8'sd20;
		tick(2);
		check(hlDeadTime, 8'sd20);
		check(lhDeadTime, 8'sd0);
		hlUpperLimit = 8'sd60;
		// Adaptive mode, then freezing keeps the last time in use.
		a = 20 + $urandom % 40;
		b = 20 + $urandom % 40;
		adaptHlTime = 8'(a);
		adaptLhTime = 8'(b);
		cmd(1'b1, CMD_DTCFG, 16'h0000);
		tick(2);
		check(hlDeadTime, 8'(a));
		check(lhDeadTime, 8'(b));
		cmd(1'b1, CMD_DTCFG, 16'h8080);
		adaptHlTime = 8'sd5;
		adaptLhTime = 8'sd5;
		rd(CMD_DT, {1'b0, 8'(a), 8'(b)});
		tick(2);
		check(hlDeadTime, 8'(a));
		cmd(1'b1, CMD_DTCFG, 16'h0a0a);
		tick(2);
		check({hlDeadTime, lhDeadTime}, 16'h1414);
		// Written sequencing replaces the strap; prequel rail 3, sequel 5.
		cmd(1'b1, CMD_SEQ, 16'h8385);
		rd(CMD_SEQ, 17'h08385);
		ev(5'd7, 1'b1);
		ev(5'd1, 1'b1);
		tick(6);
		check(outputEnable, 1'b0);
		ev(5'd3, 1'b1);
		waitOe(1'b1, 8);
		check(outputEnable, 1'b1);
		ev(5'd5, 1'b0);
		waitOe(1'b0, 16);
		check(n >= 4 && outputEnable === 1'b0, 1'b1);
		ev(5'd5, 1'b1);
		waitOe(1'b1, 8);
		check(outputEnable, 1'b1);
		cmd(1'b1, CMD_SEQ, 16'hffff);
		rd(CMD_SEQ, 17'h09f9f);
		// Tracking ratio, limit and downward following before power-good.
		cmd(1'b1, CMD_TRACK, 16'h00ff);
		rd(CMD_TRACK, 17'h00087);
		cmd(1'b1, CMD_TRACK, 16'h0080);
		tick(2);
		check({trackActive, trackSetpoint}, 13'h1400);
		cmd(1'b1, CMD_TRACK, 16'h0084);
		tick(2);
		check(trackSetpoint, 12'h200);
		followReferenceInput = 12'hc00;
		cmd(1'b1, CMD_TRACK, 16'h0080);
		tick(2);
		check(trackSetpoint, 12'h800);
		cmd(1'b1, CMD_TRACK, 16'h0082);
		tick(2);
		check(trackSetpoint, 12'hc00);
		cmd(1'b1, CMD_TRACK, 16'h0080);
		powerGoodOutput = 1'b0;
		tick(2);
		followReferenceInput = 12'h400;
		tick(3);
		check(trackSetpoint, 12'h800);
		cmd(1'b1, CMD_TRACK, 16'h0081);
		tick(2);
		check(trackSetpoint, 12'h400);
		cmd(1'b1, CMD_TRACK, 16'h0000);
		tick(2);
		check({trackActive, trackSetpoint}, 13'h0800);
		tick(4);
		check(expQ.size(), 0);
		wrap_up();
	end
endmodule
